// *** logic/ast_tx.sv ***
// Asynchronous serial transmitter with holding buffer and shift register.
// Assumes one system clock; software drives the plain register port below.
//
// Behaviour
// - Line idles at mark; one is mark, zero is space.
// - Frame is start bit, eight or nine data bits, one or two stops.
// - Start bit is space, every stop bit is mark.
// - Each bit lasts exactly one bit period from the baud setting.
// - Baud generator runs off system clock, 8-bit or 16-bit divisor.
// - Data bits leave least significant bit first.
// - Format and baud setting are shared with the receiver.
// - No hardware parity; software parity rides in the ninth bit.
// - Sends only with transmit on, sync select clear, serial port on.
// - Serial port on enables the unit and drives the pin as output.
// - Turning transmit on sets the buffer empty flag.
// - Buffer write starts sending; empty shifter loads at once.
// - Queued character waits for stop bit, then loads within one cycle.
// - Polarity invert resets to zero; one inverts idle and all bits.
// - Polarity invert acts only in asynchronous operation.
// - Empty flag set when transmit on and buffer free; clear when queued.
// - Empty flag settles in the second instruction cycle after a write.
// - Empty flag is read only and reflects buffer state and the transmit-on bit.
// - Empty flag ignores its interrupt enable, which only gates the request.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module ast_tx
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Transmit pin
   output logic tx_pin_out,
   output logic tx_pin_oe_out,
   // Flag and request
   output logic tx_buffer_empty_flag_out,
   output logic tx_irq_req_out,
   // Settings shared with the receiver
   output logic rx_nine_bits_out,
   output logic rx_baud_wide_out,
   output logic [15:0] rx_baud_divisor_out
);

   // ==========================================================
   // Declarations
   logic [8:0] ctrl_q;
   logic [8:0] ctrl_d;
   logic [7:0] baud_lo_q;
   logic [7:0] baud_lo_d;
   logic [7:0] baud_hi_q;
   logic [7:0] baud_hi_d;
   logic [8:0] hold_q;
   logic [8:0] hold_d;
   logic hold_full_q;
   logic hold_full_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   ast_pkg::ast_state_t state_q;
   ast_pkg::ast_state_t state_d;
   logic [8:0] shift_q;
   logic [8:0] shift_d;
   logic [3:0] bits_left_q;
   logic [3:0] bits_left_d;
   logic stop_left_q;
   logic stop_left_d;
   logic line_q;
   logic line_d;
   logic flag_q;
   logic flag_d;
   logic [2:0] settle_q;
   logic [2:0] settle_d;
   logic tx_on_prev_q;
   logic enabled;
   logic invert;
   logic load;
   logic raw_bit;
   logic wr_hold;
   logic tx_on_rise;
   logic true_empty;

   ast_baud_if baud_link ();

   // ==========================================================
   // Control decode
   assign enabled = ctrl_q[ast_pkg::CB_TRANSMIT_ON] & ~ctrl_q[ast_pkg::CB_SYNC_SELECT]
      & ctrl_q[ast_pkg::CB_SERIAL_PORT_ON];
   // Inversion only in asynchronous operation; sync mode uses the bit elsewhere
   assign invert = ctrl_q[ast_pkg::CB_POLARITY_INVERT]
      & ~ctrl_q[ast_pkg::CB_SYNC_SELECT];
   assign wr_hold = reg_wr_in && (reg_addr_in == ast_pkg::REG_HOLD);
   assign tx_on_rise = ctrl_q[ast_pkg::CB_TRANSMIT_ON] & ~tx_on_prev_q;
   // Shifter takes the buffer whenever it is enabled and idle and a character waits
   assign load = enabled && (state_q == ast_pkg::ST_IDLE) && hold_full_q;

   // ==========================================================
   // Baud generator, shared divisor and format with the receiver
   assign baud_link.restart = load;
   assign baud_link.wide = ctrl_q[ast_pkg::CB_BAUD_WIDE];
   assign baud_link.divisor = {baud_hi_q, baud_lo_q};

   ast_baud_gen u_baud
   (
      .sys_clk_in (sys_clk_in),
      .sys_rst_in (sys_rst_in),
      .baud (baud_link.gen)
   );

   assign rx_nine_bits_out = ctrl_q[ast_pkg::CB_NINE_BITS];
   assign rx_baud_wide_out = ctrl_q[ast_pkg::CB_BAUD_WIDE];
   assign rx_baud_divisor_out = {baud_hi_q, baud_lo_q};

   // ==========================================================
   // Register writes and reads
   always_comb
   begin
      ctrl_d = ctrl_q;
      baud_lo_d = baud_lo_q;
      baud_hi_d = baud_hi_q;
      rdata_d = 32'h0000_0000;
      if (reg_wr_in)
      begin
         // Status writes fall through: the flag cannot be forced
         unique case (reg_addr_in)
            ast_pkg::REG_CTRL: ctrl_d = reg_wdata_in[8:0];
            ast_pkg::REG_BAUD_LO: baud_lo_d = reg_wdata_in[7:0];
            ast_pkg::REG_BAUD_HI: baud_hi_d = reg_wdata_in[7:0];
            default: ctrl_d = ctrl_q;
         endcase
      end
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            ast_pkg::REG_CTRL: rdata_d = {23'h00_0000, ctrl_q};
            ast_pkg::REG_BAUD_LO: rdata_d = {24'h00_0000, baud_lo_q};
            ast_pkg::REG_BAUD_HI: rdata_d = {24'h00_0000, baud_hi_q};
            ast_pkg::REG_STATUS:
            begin
               rdata_d[ast_pkg::SB_EMPTY_FLAG] = flag_q;
               rdata_d[ast_pkg::SB_SHIFT_BUSY] = (state_q != ast_pkg::ST_IDLE);
               rdata_d[ast_pkg::SB_LINE_LEVEL] = line_q;
            end
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         ctrl_q <= ast_pkg::CTRL_RESET;
         baud_lo_q <= ast_pkg::BAUD_LO_RESET;
         baud_hi_q <= ast_pkg::BAUD_HI_RESET;
         rdata_q <= 32'h0000_0000;
         tx_on_prev_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         baud_lo_q <= baud_lo_d;
         baud_hi_q <= baud_hi_d;
         rdata_q <= rdata_d;
         tx_on_prev_q <= ctrl_q[ast_pkg::CB_TRANSMIT_ON];
      end
   end

   assign reg_rdata_out = rdata_q;

   // ==========================================================
   // Holding buffer; ninth bit is captured with the character
   always_comb
   begin
      hold_d = hold_q;
      hold_full_d = hold_full_q;
      if (load)
      begin
         hold_full_d = 1'b0;
      end
      // A write in the load cycle refills the buffer: the new character wins
      if (wr_hold)
      begin
         hold_d = {ctrl_q[ast_pkg::CB_NINTH_DATA], reg_wdata_in[7:0]};
         hold_full_d = 1'b1;
      end
      if (!ctrl_q[ast_pkg::CB_TRANSMIT_ON])
      begin
         hold_full_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         hold_q <= 9'h000;
         hold_full_q <= 1'b0;
      end
      else
      begin
         hold_q <= hold_d;
         hold_full_q <= hold_full_d;
      end
   end

   // ==========================================================
   // Frame sequencer: start, data LSB first, stop bits
   always_comb
   begin
      state_d = state_q;
      shift_d = shift_q;
      bits_left_d = bits_left_q;
      stop_left_d = stop_left_q;
      raw_bit = ast_pkg::MARK;
      unique case (state_q)
         ast_pkg::ST_IDLE:
         begin
            if (load)
            begin
               shift_d = hold_q;
               bits_left_d = ctrl_q[ast_pkg::CB_NINE_BITS] ?
                  ast_pkg::BITS_NINE : ast_pkg::BITS_EIGHT;
               stop_left_d = ctrl_q[ast_pkg::CB_TWO_STOP];
               state_d = ast_pkg::ST_START;
            end
         end
         ast_pkg::ST_START:
         begin
            raw_bit = ast_pkg::SPACE;
            if (baud_link.tick)
            begin
               state_d = ast_pkg::ST_DATA;
            end
         end
         ast_pkg::ST_DATA:
         begin
            raw_bit = shift_q[0];
            if (baud_link.tick)
            begin
               shift_d = {1'b0, shift_q[8:1]};
               bits_left_d = bits_left_q - 4'h1;
               if (bits_left_q == 4'h1)
               begin
                  state_d = ast_pkg::ST_STOP;
               end
            end
         end
         ast_pkg::ST_STOP:
         begin
            raw_bit = ast_pkg::MARK;
            if (baud_link.tick)
            begin
               // Idle then reloads at once if a character waits
               if (stop_left_q)
               begin
                  stop_left_d = 1'b0;
               end
               else
               begin
                  state_d = ast_pkg::ST_IDLE;
               end
            end
         end
      endcase
      if (!enabled)
      begin
         state_d = ast_pkg::ST_IDLE;
      end
      line_d = raw_bit ^ invert;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         state_q <= ast_pkg::ST_IDLE;
         shift_q <= 9'h000;
         bits_left_q <= 4'h0;
         stop_left_q <= 1'b0;
         line_q <= ast_pkg::MARK;
      end
      else
      begin
         state_q <= state_d;
         shift_q <= shift_d;
         bits_left_q <= bits_left_d;
         stop_left_q <= stop_left_d;
         line_q <= line_d;
      end
   end

   // Pin drive follows the serial-port-on bit alone
   assign tx_pin_out = line_q;
   assign tx_pin_oe_out = ctrl_q[ast_pkg::CB_SERIAL_PORT_ON];

   // ==========================================================
   // Buffer-empty flag; frozen briefly after a write, so early polls are stale
   assign true_empty = ctrl_q[ast_pkg::CB_TRANSMIT_ON] & ~hold_full_q;

   always_comb
   begin
      settle_d = (settle_q != 3'h0) ? settle_q - 3'h1 : 3'h0;
      flag_d = true_empty;
      if (wr_hold)
      begin
         settle_d = ast_pkg::FLAG_SETTLE_CLKS;
      end
      if (settle_q != 3'h0)
      begin
         flag_d = flag_q;
      end
      if (tx_on_rise)
      begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         flag_q <= 1'b0;
         settle_q <= 3'h0;
      end
      else
      begin
         flag_q <= flag_d;
         settle_q <= settle_d;
      end
   end

   assign tx_buffer_empty_flag_out = flag_q;
   assign tx_irq_req_out = flag_q & ctrl_q[ast_pkg::CB_IRQ_ENABLE];

   // ==========================================================
   // Checks
   logic [15:0] period_q;
   logic [15:0] limit_w;
   logic [15:0] limit_prev_q;
   logic period_ok_q;

   assign limit_w = ctrl_q[ast_pkg::CB_BAUD_WIDE] ?
      {baud_hi_q, baud_lo_q} : {8'h00, baud_lo_q};

   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in || load || baud_link.tick)
      begin
         period_q <= 16'h0000;
      end
      else
      begin
         period_q <= period_q + 16'h0001;
      end
   end

   // Period is known only once a tick or a load has lined the counter up with the setting
   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         limit_prev_q <= 16'h0000;
         period_ok_q <= 1'b0;
      end
      else
      begin
         limit_prev_q <= limit_w;
         if (limit_w != limit_prev_q)
         begin
            period_ok_q <= 1'b0;
         end
         else if (load || baud_link.tick)
         begin
            period_ok_q <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence load_seq;
      load;
   endsequence
   sequence start_seq;
      state_q == ast_pkg::ST_START;
   endsequence

   idle_line_mark_a: assert property (
      (state_q == ast_pkg::ST_IDLE) && $past(state_q == ast_pkg::ST_IDLE)
      |-> (line_q == (ast_pkg::MARK ^ $past(invert))))
      else $error("idle line not at mark");
   start_bit_space_a: assert property (
      start_seq ##1 start_seq |-> line_q == (ast_pkg::SPACE ^ $past(invert)))
      else $error("start bit not space");
   stop_bit_mark_a: assert property (
      (state_q == ast_pkg::ST_STOP) ##1 (state_q == ast_pkg::ST_STOP)
      |-> line_q == (ast_pkg::MARK ^ $past(invert)))
      else $error("stop bit not mark");
   bit_period_a: assert property (
      baud_link.tick && period_ok_q && $stable(limit_w) |-> period_q == limit_w)
      else $error("bit period wrong");
   load_start_a: assert property (
      load_seq |=> start_seq ##0 (shift_q == $past(hold_q)))
      else $error("buffer not loaded at once");
   lsb_first_a: assert property (
      (state_q == ast_pkg::ST_DATA) && baud_link.tick && enabled
      |=> shift_q == {1'b0, $past(shift_q[8:1])})
      else $error("data not shifted lsb first");
   enable_gate_a: assert property (
      !enabled |=> state_q == ast_pkg::ST_IDLE)
      else $error("sending while disabled");
   pin_drive_a: assert property (
      tx_pin_oe_out == ctrl_q[ast_pkg::CB_SERIAL_PORT_ON])
      else $error("pin direction wrong");
   enable_sets_flag_a: assert property (
      tx_on_rise |=> flag_q)
      else $error("flag not set on enable");
   flag_settle_a: assert property (
      wr_hold && !tx_on_rise |=> $stable(flag_q) [*4])
      else $error("flag moved before settling");
   irq_gate_a: assert property (
      tx_irq_req_out == (flag_q && ctrl_q[ast_pkg::CB_IRQ_ENABLE]))
      else $error("request not gated by enable");

endmodule

// *** include/ast_pkg.sv ***
// Constants shared by the asynchronous serial transmitter and its bench.
// Assumes a 100 MHz system clock and a word-wide register port on byte addresses.
package ast_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int INSTR_CYCLE_NS = 40;
   localparam int INSTR_CYCLE_CLKS =
      (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] FLAG_SETTLE_CLKS = 3'(INSTR_CYCLE_CLKS);

   // ==========================================================
   // Register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BAUD_LO = 8'h04;
   localparam logic [7:0] REG_BAUD_HI = 8'h08;
   localparam logic [7:0] REG_HOLD = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;

   // ==========================================================
   // Control register fields
   localparam int CTRL_W = 9;
   localparam int CB_TRANSMIT_ON = 0;
   localparam int CB_SYNC_SELECT = 1;
   localparam int CB_SERIAL_PORT_ON = 2;
   localparam int CB_NINE_BITS = 3;
   localparam int CB_NINTH_DATA = 4;
   localparam int CB_POLARITY_INVERT = 5;
   localparam int CB_BAUD_WIDE = 6;
   localparam int CB_TWO_STOP = 7;
   localparam int CB_IRQ_ENABLE = 8;
   localparam logic [8:0] CTRL_RESET = 9'h000;

   // Status register fields
   localparam int SB_EMPTY_FLAG = 0;
   localparam int SB_SHIFT_BUSY = 1;
   localparam int SB_LINE_LEVEL = 2;

   // ==========================================================
   // Frame, line levels and baud register resets
   localparam logic MARK = 1'b1;
   localparam logic SPACE = 1'b0;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [7:0] BAUD_LO_RESET = 8'h00;
   localparam logic [7:0] BAUD_HI_RESET = 8'h00;

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} ast_state_t;

endpackage

// *** include/ast_baud_if.sv ***
// Link between the transmitter core and its baud generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface ast_baud_if;
   logic restart;
   logic wide;
   logic [15:0] divisor;
   logic tick;

   // ==========================================================
   // Views
   modport gen (input restart, input wide, input divisor, output tick);
   modport user (output restart, output wide, output divisor, input tick);
endinterface

// *** logic/ast_baud_gen.sv ***
// Baud generator: one tick every divisor+1 system clocks, 8-bit or 16-bit divisor.
// Assumes the core pulses restart on the cycle a frame is loaded.
`timescale 1ns/1ps
module ast_baud_gen
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Core side
   ast_baud_if.gen baud
);

   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] limit;
   logic tick_q;
   logic tick_d;

   // ==========================================================
   // Divider; narrow mode ignores the high byte
   always_comb
   begin
      limit = baud.wide ? baud.divisor : {8'h00, baud.divisor[7:0]};
      tick_d = 1'b0;
      cnt_d = cnt_q + 16'h0001;
      if (baud.restart)
      begin
         // Restart is the first clock of the start bit, or that bit runs one clock long
         cnt_d = (limit == 16'h0000) ? 16'h0000 : 16'h0001;
         tick_d = (limit == 16'h0000);
      end
      else if (cnt_q >= limit)
      begin
         cnt_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (sys_rst_in)
      begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   // Registered tick lags the count by one, which keeps the period exact
   assign baud.tick = tick_q;

endmodule

// *** dv/ast_rx_model.sv ***
// Behavioural remote receiver listening on the transmit line.
// Assumes the bench sets format and bit length while listening is off.
`timescale 1ns/1ps
module ast_rx_model
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   // Line and expected format
   input wire logic line_in,
   input wire logic listen_in,
   input wire logic invert_in,
   input wire logic nine_in,
   input wire logic two_stop_in,
   input wire logic [16:0] bit_clks_in,
   // Results
   output logic [8:0] rx_data_out,
   output logic rx_err_out,
   output logic [15:0] frames_out
);
   // ==========================================================
   // Frame capture
   // Samples mid-bit, so a wrong bit length walks the sample off its bit
   initial
   begin
      rx_data_out = '0;
      rx_err_out = 1'b0;
      frames_out = '0;
      forever
      begin
         @(posedge sys_clk_in);
         if (!sys_rst_in && listen_in && (line_in ^ invert_in) === 1'b0)
         begin
            repeat (bit_clks_in / 2 - 1) @(posedge sys_clk_in);
            if ((line_in ^ invert_in) !== 1'b0) rx_err_out = 1'b1;
            for (int i = 0; i < (nine_in ? 9 : 8); i++)
            begin
               repeat (bit_clks_in) @(posedge sys_clk_in);
               rx_data_out[i] = line_in ^ invert_in;
            end
            for (int s = 0; s < (two_stop_in ? 2 : 1); s++)
            begin
               repeat (bit_clks_in) @(posedge sys_clk_in);
               if ((line_in ^ invert_in) !== 1'b1) rx_err_out = 1'b1;
            end
            frames_out = frames_out + 16'h0001;
         end
      end
   end
endmodule

// *** dv/ast_tx_tb.sv ***
// Self-checking bench for the asynchronous serial transmitter.
// Assumes the receiver model in this folder and the shared package.
`timescale 1ns/1ps
module ast_tx_tb;
   typedef struct {logic [31:0] mods; logic [7:0] data; logic [8:0] exp; logic idle;} ast_row_t;
   localparam logic [31:0] ON_BITS = 32'h0000_0005;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic pin, oe, flag, irq, nine_o, wide_o;
   logic [15:0] div_o;
   logic listen = 1'b0;
   logic inv = 1'b0;
   logic nine = 1'b0;
   logic two = 1'b0;
   logic [16:0] bp = 17'h0_0004;
   logic [8:0] rxd;
   logic rxe;
   logic [15:0] frames;
   logic [31:0] st;
   int mismatches = 0;
   int samples_checked = 0;
   int gap;
   // Ordinary frames: control extras, character, received value, idle level
   ast_row_t rows [6] = '{
      '{32'h0000_0000, 8'h55, 9'h055, 1'b1},
      '{32'h0000_0018, 8'hA3, 9'h1A3, 1'b1},
      '{32'h0000_0008, 8'hFF, 9'h0FF, 1'b1},
      '{32'h0000_0020, 8'h3C, 9'h03C, 1'b0},
      '{32'h0000_0080, 8'h81, 9'h081, 1'b1},
      '{32'h0000_0050, 8'h6E, 9'h06E, 1'b1}};

   // ==========================================================
   // Design, far side and clock
   ast_tx ast_tx_i (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata), .tx_pin_out(pin), .tx_pin_oe_out(oe),
      .tx_buffer_empty_flag_out(flag), .tx_irq_req_out(irq), .rx_nine_bits_out(nine_o),
      .rx_baud_wide_out(wide_o), .rx_baud_divisor_out(div_o));
   ast_rx_model ast_rx_model_i (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .line_in(pin),
      .listen_in(listen), .invert_in(inv), .nine_in(nine), .two_stop_in(two),
      .bit_clks_in(bp), .rx_data_out(rxd), .rx_err_out(rxe), .frames_out(frames));
   always #(ast_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Listening stops while the format changes, or a polarity flip looks like a start bit
   task automatic set_fmt(input logic [31:0] c);
      listen <= 1'b0;
      reg_write(ast_pkg::REG_CTRL, c);
      inv <= c[ast_pkg::CB_POLARITY_INVERT] & ~c[ast_pkg::CB_SYNC_SELECT];
      nine <= c[ast_pkg::CB_NINE_BITS];
      two <= c[ast_pkg::CB_TWO_STOP];
      bp <= c[ast_pkg::CB_BAUD_WIDE] ? 17'h0_0104 : 17'h0_0004;
      repeat (3) @(posedge sys_clk);
      listen <= 1'b1;
      #1;
   endtask
   task automatic wait_frames(input int n);
      int guard = 0;
      while (int'(frames) < n && guard < 20000)
      begin
         @(posedge sys_clk);
         guard++;
      end
      check(32'(frames), 32'(n), "frame count");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================================
   // Watchdog, sized well past the longest expected run
   initial
   begin
      #200_000;
      mismatches++;
      $display("BAD t=%0t watchdog expired", $time);
      final_report();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge sys_clk);
      #1;
      check(32'({pin, oe, flag}), 32'h4, "pins in reset");
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      reg_read(ast_pkg::REG_CTRL, st);
      check(st, 32'h0, "control reset");
      reg_read(ast_pkg::REG_STATUS, st);
      check(st, 32'h4, "status reset");
      reg_read(8'h14, st);
      check(st, 32'h0, "unmapped read");
      // Port on alone keeps the flag low; transmit on raises it
      reg_write(ast_pkg::REG_CTRL, 32'h0000_0004); // pin is digital only here
      repeat (2) @(posedge sys_clk);
      #1;
      check(32'({oe, flag}), 32'h2, "port only");
      reg_write(ast_pkg::REG_CTRL, ON_BITS);
      repeat (2) @(posedge sys_clk);
      #1;
      check(32'(flag), 32'h1, "flag on enable");
      reg_write(ast_pkg::REG_BAUD_LO, 32'h0000_0003);
      reg_write(ast_pkg::REG_BAUD_HI, 32'h0000_0001);
      reg_write(ast_pkg::REG_STATUS, 32'h0000_0000);
      reg_read(ast_pkg::REG_STATUS, st);
      check(st & 32'h0000_0001, 32'h1, "flag after write");
      check(32'(div_o), 32'h0103, "shared divisor");
      foreach (rows[k])
      begin
         set_fmt(ON_BITS | rows[k].mods);
         check(32'({oe, nine_o, wide_o}), 32'({1'b1, rows[k].mods[3], rows[k].mods[6]}),
            "pin and shared format");
         reg_write(ast_pkg::REG_HOLD, 32'(rows[k].data));
         wait_frames(int'(frames) + 1);
         check(32'(rxd), 32'(rows[k].exp), "frame data");
         check(32'(rxe), 32'h0, "framing");
         repeat (int'(bp) + 3) @(posedge sys_clk);
         #1;
         check(32'(pin), 32'(rows[k].idle), "idle level");
         reg_read(ast_pkg::REG_STATUS, st);
         check(st & 32'h0000_0003, 32'h1, "status after frame");
      end
      // Back to back with the request enabled: second character queues
      set_fmt(ON_BITS | 32'h0000_0100);
      reg_write(ast_pkg::REG_HOLD, 32'h0000_0096);
      reg_write(ast_pkg::REG_HOLD, 32'h0000_003B);
      @(posedge sys_clk);
      #1;
      check(32'({flag, irq}), 32'h3, "flag before settling");
      repeat (5) @(posedge sys_clk);
      #1;
      check(32'({flag, irq}), 32'h0, "flag with queued char");
      reg_write(ast_pkg::REG_CTRL, ON_BITS);
      wait_frames(int'(frames) + 1);
      check(32'(rxd), 32'h096, "first queued frame");
      gap = 0;
      while (pin !== 1'b0 && gap < 20)
      begin
         @(posedge sys_clk);
         gap++;
      end
      check(32'(gap <= 7), 32'h1, "gap between frames");
      wait_frames(int'(frames) + 1);
      check(32'(rxd), 32'h03B, "second queued frame");
      repeat (8) @(posedge sys_clk);
      #1;
      check(32'({flag, irq}), 32'h2, "flag without request");
      // Synchronous select blocks sending and ignores polarity invert
      set_fmt(ON_BITS | 32'h0000_0022);
      reg_write(ast_pkg::REG_HOLD, 32'h0000_0000);
      repeat (50) @(posedge sys_clk);
      #1;
      check(32'({pin, frames}), {15'h0, 1'b1, 16'h0008}, "sync blocks");
      // Transmit off: flag low and nothing sent
      set_fmt(32'h0000_0004);
      reg_write(ast_pkg::REG_HOLD, 32'h0000_0000);
      repeat (50) @(posedge sys_clk);
      #1;
      check(32'({pin, flag, frames}), {14'h0, 2'b10, 16'h0008}, "off blocks");
      final_report();
   end
endmodule
